// [verilog/swt_pkg.sv]
// Purpose: Shared constants and carriers for the system watchdog timer
// Assumes: AXI4-Lite register access, 32-bit data, one clock at 50 MHz
// Notes:   Offsets are byte addresses of aligned words
package swt_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int SWT_ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [SWT_ADDR_W-1:0] OFF_WDOG = 8'h00;    // watchdog_ctrl_status
    localparam logic [SWT_ADDR_W-1:0] OFF_CLKCFG = 8'h04;  // clock_timing_config
    localparam logic [SWT_ADDR_W-1:0] OFF_IRQEN = 8'h08;   // extended_irq_enable
    localparam logic [SWT_ADDR_W-1:0] OFF_GIRQ = 8'h0c;    // global_irq_enable holder
    localparam logic [SWT_ADDR_W-1:0] OFF_TAKEY = 8'h10;   // Timed access key port

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_RESTART = 0;
    localparam int BIT_RST_EN = 1;
    localparam int BIT_RST_CAUSE = 2;
    localparam int BIT_TIMEOUT = 3;
    localparam int BIT_SEL_LO = 6;
    localparam int BIT_SEL_HI = 7;
    localparam int BIT_WDOG_IE = 4;
    localparam int BIT_GLOBAL_IE = 7;
    localparam logic [7:0] CLKCFG_RESET = 8'h00;
    localparam logic [7:0] IRQEN_RESET = 8'h00;
    localparam logic [7:0] GIRQ_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Timed access keys
    // ----------------------------------------------------------------
    localparam logic [7:0] TA_KEY1 = 8'haa;
    localparam logic [7:0] TA_KEY2 = 8'h55;

    // ----------------------------------------------------------------
    // Timing, in Hz, system clocks and machine cycles
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int MCYCLE_CLKS = 4;
    localparam int WDRST_MCYCLES = 2;
    localparam int WDRST_CLKS = WDRST_MCYCLES * MCYCLE_CLKS;
    localparam int GRACE_CLKS = 512;
    localparam int TA_WINDOW_MCYCLES = 3;
    localparam int TA_WINDOW_CLKS = TA_WINDOW_MCYCLES * MCYCLE_CLKS;

    typedef enum logic [1:0] {
        TA_IDLE,
        TA_GOT_KEY1,
        TA_OPEN
    } swt_ta_state_t;

    typedef struct packed {
        logic awvalid;
        logic [SWT_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [SWT_ADDR_W-1:0] araddr;
        logic rready;
    } swt_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } swt_axil_rsp_t;

endpackage

// [verilog/swt_watchdog.sv]
// Purpose: System watchdog timer with timed-access protected controls
// Assumes: rst_n is the power-on/fail reset; bus master follows AXI4-Lite
// Notes:   wdog_sys_rst is the watchdog-caused system reset request
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - Counts system clocks from restart to interval
// - Select 00..11 gives 2^17/2^20/2^23/2^26 clocks
// - Select bits sit at config bits 7:6
// - Select resets to shortest interval
// - Interval end sets time-out flag bit 3
// - Without enables, flag sets every interval
// - Restart bit clears counter, self-clears
// - Reset 512 clocks after time-out if enabled
// - Watchdog reset lasts two machine cycles, sets cause
// - Reset enable arms reset; counter keeps running
// - Interrupt needs flag, own and global enable
// - Interrupt and reset enabled independently
// - Software or any reset clears time-out flag
// - Cause flag cleared by software or power reset
// - Power reset disables; watchdog reset restarts counter
// - Protected bits change only via timed access
module swt_watchdog #(
    parameter int CNT_W = 27,
    parameter int TO_CLKS_0 = 131072,
    parameter int TO_CLKS_1 = 1048576,
    parameter int TO_CLKS_2 = 8388608,
    parameter int TO_CLKS_3 = 67108864
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire swt_pkg::swt_axil_req_t req,
    output swt_pkg::swt_axil_rsp_t rsp,
    output logic wdog_irq,
    output logic wdog_sys_rst
);
    import swt_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] clock_timing_config, extended_irq_enable, global_irq_reg;
    logic wdog_timeout_flag, wdog_reset_cause_flag, wdog_reset_enable, running, grace_on;
    logic [CNT_W-1:0] cnt, limit_m1;
    logic [9:0] grace_cnt;
    logic [3:0] rst_cnt, ta_cnt;
    swt_ta_state_t ta_state;
    logic wr_hit, rd_hit, wr_lane, wr_mapped, rd_mapped;
    logic wdog_wr, prot_wr, ta_wr, wdog_restart, timeout, wd_fire;
    logic [31:0] next_rdata;
    localparam logic [9:0] GRACE_LAST = 10'(GRACE_CLKS - 1);
    localparam logic [3:0] WDRST_LAST = 4'(WDRST_CLKS - 1);
    localparam logic [3:0] TA_LAST = 4'(TA_WINDOW_CLKS - 1);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Write happens on the address/data handshake cycle
    assign wr_hit = req.awvalid && rsp.awready;
    assign rd_hit = req.arvalid && rsp.arready;
    assign wr_lane = req.wstrb[0];
    assign wr_mapped = (req.awaddr[1:0] == 2'h0) && (req.awaddr <= OFF_TAKEY);
    assign rd_mapped = (req.araddr[1:0] == 2'h0) && (req.araddr <= OFF_TAKEY);
    assign wdog_wr = wr_hit && wr_lane && (req.awaddr == OFF_WDOG);
    assign ta_wr = wr_hit && wr_lane && (req.awaddr == OFF_TAKEY);
    assign prot_wr = wdog_wr && (ta_state == TA_OPEN);
    assign wdog_restart = prot_wr && req.wdata[BIT_RESTART];
    // Read data mux; restart bit and key port read as zero
    always_comb begin
        next_rdata = 32'h0;
        case (req.araddr)
            OFF_WDOG: next_rdata[BIT_TIMEOUT:BIT_RST_EN] = {wdog_timeout_flag,
                wdog_reset_cause_flag, wdog_reset_enable};
            OFF_CLKCFG: next_rdata[7:0] = clock_timing_config;
            OFF_IRQEN: next_rdata[7:0] = extended_irq_enable;
            OFF_GIRQ: next_rdata[7:0] = global_irq_reg;
            default: next_rdata = 32'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave handshakes
    // ----------------------------------------------------------------
    // Address and data are taken together once both are offered
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp <= '0;
        end else begin
            rsp.awready <= req.awvalid && req.wvalid && !rsp.awready && !rsp.bvalid;
            rsp.wready <= req.awvalid && req.wvalid && !rsp.awready && !rsp.bvalid;
            if (wr_hit) begin
                rsp.bvalid <= 1'b1;
                rsp.bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (req.bready) begin
                rsp.bvalid <= 1'b0;
            end
            rsp.arready <= req.arvalid && !rsp.arready && !rsp.rvalid;
            if (rd_hit) begin
                rsp.rvalid <= 1'b1;
                rsp.rdata <= next_rdata;
                rsp.rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (req.rready) begin
                rsp.rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Plain configuration registers
    // ----------------------------------------------------------------
    // Select field resets to the shortest interval
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clock_timing_config <= CLKCFG_RESET;
            extended_irq_enable <= IRQEN_RESET;
            global_irq_reg <= GIRQ_RESET;
        end else if (wr_hit && wr_lane) begin
            case (req.awaddr)
                OFF_CLKCFG: clock_timing_config <= req.wdata[7:0];
                OFF_IRQEN: extended_irq_enable <= req.wdata[7:0];
                OFF_GIRQ: global_irq_reg <= req.wdata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Timed access unlock
    // ----------------------------------------------------------------
    // Two key writes open a short window; one protected write closes it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ta_state <= TA_IDLE;
            ta_cnt <= 4'h0;
        end else if (prot_wr) begin
            ta_state <= TA_IDLE;
        end else begin
            case (ta_state)
                TA_IDLE: begin
                    if (ta_wr && req.wdata[7:0] == TA_KEY1) begin
                        ta_state <= TA_GOT_KEY1;
                        ta_cnt <= TA_LAST;
                    end
                end
                TA_GOT_KEY1: begin
                    if (ta_wr) begin
                        ta_state <= (req.wdata[7:0] == TA_KEY2) ? TA_OPEN : TA_IDLE;
                        ta_cnt <= TA_LAST;
                    end else if (ta_cnt == 4'h0) begin
                        ta_state <= TA_IDLE;
                    end else begin
                        ta_cnt <= ta_cnt - 4'h1;
                    end
                end
                TA_OPEN: begin
                    if (ta_cnt == 4'h0) begin
                        ta_state <= TA_IDLE;
                    end else begin
                        ta_cnt <= ta_cnt - 4'h1;
                    end
                end
                default: ta_state <= TA_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Interval counter
    // ----------------------------------------------------------------
    // Interval lookup from the two select bits
    always_comb begin
        case ({clock_timing_config[BIT_SEL_HI], clock_timing_config[BIT_SEL_LO]})
            2'h0: limit_m1 = CNT_W'(TO_CLKS_0 - 1);
            2'h1: limit_m1 = CNT_W'(TO_CLKS_1 - 1);
            2'h2: limit_m1 = CNT_W'(TO_CLKS_2 - 1);
            default: limit_m1 = CNT_W'(TO_CLKS_3 - 1);
        endcase
    end
    assign timeout = running && !wdog_sys_rst && !wdog_restart && (cnt == limit_m1);
    // Running flag: off after power reset, on after first restart
    always_ff @(posedge clock) begin
        running <= rst_n && (running || wdog_restart);
    end
    // Free divider of system clocks, wraps every interval
    always_ff @(posedge clock) begin
        if (!rst_n || wdog_sys_rst || wdog_restart) begin
            cnt <= '0;
        end else if (running) begin
            cnt <= (cnt == limit_m1) ? '0 : cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Grace phase and watchdog reset
    // ----------------------------------------------------------------
    assign wd_fire = grace_on && (grace_cnt == GRACE_LAST) && wdog_reset_enable &&
                     !wdog_restart;
    // 512-clock wait after each time-out; a restart cancels it
    always_ff @(posedge clock) begin
        if (!rst_n || wdog_sys_rst || wdog_restart) begin
            grace_on <= 1'b0;
            grace_cnt <= 10'h0;
        end else if (timeout) begin
            grace_on <= 1'b1;
            grace_cnt <= 10'h0;
        end else if (grace_on) begin
            grace_on <= (grace_cnt != GRACE_LAST);
            grace_cnt <= grace_cnt + 10'h1;
        end
    end
    // Reset pulse of two machine cycles
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wdog_sys_rst <= 1'b0;
            rst_cnt <= 4'h0;
        end else if (wd_fire) begin
            wdog_sys_rst <= 1'b1;
            rst_cnt <= 4'h0;
        end else if (wdog_sys_rst) begin
            wdog_sys_rst <= (rst_cnt != WDRST_LAST);
            rst_cnt <= rst_cnt + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Control and status flags
    // ----------------------------------------------------------------
    // Time-out flag: set wins over a software clear
    always_ff @(posedge clock) begin
        if (!rst_n || wdog_sys_rst) begin
            wdog_timeout_flag <= 1'b0;
        end else if (timeout) begin
            wdog_timeout_flag <= 1'b1;
        end else if (prot_wr) begin
            wdog_timeout_flag <= req.wdata[BIT_TIMEOUT];
        end
    end
    // Reset cause: set by a watchdog reset, cleared by writing zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wdog_reset_cause_flag <= 1'b0;
        end else if (wd_fire) begin
            wdog_reset_cause_flag <= 1'b1;
        end else if (wdog_wr && !req.wdata[BIT_RST_CAUSE]) begin
            wdog_reset_cause_flag <= 1'b0;
        end
    end
    // Reset enable survives a watchdog reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wdog_reset_enable <= 1'b0;
        end else if (prot_wr) begin
            wdog_reset_enable <= req.wdata[BIT_RST_EN];
        end
    end
    // Interrupt request, independent of the reset path
    always_ff @(posedge clock) begin
        wdog_irq <= rst_n && wdog_timeout_flag && extended_irq_enable[BIT_WDOG_IE] &&
                    global_irq_reg[BIT_GLOBAL_IE];
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_flag_on_timeout;
        timeout |=> wdog_timeout_flag && grace_on && cnt == '0;
    endproperty
    a_flag_on_timeout: assert property (p_flag_on_timeout)
        else $error("time-out did not set flag and start grace");
    property p_interval_sel0;
        timeout && clock_timing_config[7:6] == 2'h0 |-> cnt == CNT_W'(TO_CLKS_0 - 1);
    endproperty
    a_interval_sel0: assert property (p_interval_sel0)
        else $error("shortest interval has wrong length");
    property p_restart_clears;
        wdog_restart |=> cnt == '0 && !grace_on && running;
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("restart did not clear counter");
    property p_grace_cancel;
        grace_on && wdog_restart |=> !grace_on ##1 !wdog_sys_rst;
    endproperty
    a_grace_cancel: assert property (p_grace_cancel)
        else $error("restart in grace left reset pending");
    property p_reset_after_grace;
        $rose(wdog_sys_rst) |-> $past(grace_cnt) == GRACE_LAST && $past(wdog_reset_enable);
    endproperty
    a_reset_after_grace: assert property (p_reset_after_grace)
        else $error("watchdog reset not 512 clocks after time-out");
    property p_reset_width;
        $rose(wdog_sys_rst) |-> wdog_sys_rst [*8] ##1 !wdog_sys_rst;
    endproperty
    a_reset_width: assert property (p_reset_width)
        else $error("watchdog reset width wrong");
    property p_cause_set;
        $rose(wdog_sys_rst) |-> wdog_reset_cause_flag;
    endproperty
    a_cause_set: assert property (p_cause_set)
        else $error("reset cause not recorded");
    property p_no_cause_when_disarmed;
        !wdog_reset_enable |=> !$rose(wdog_reset_cause_flag) && !$rose(wdog_sys_rst);
    endproperty
    a_no_cause_when_disarmed: assert property (p_no_cause_when_disarmed)
        else $error("disarmed watchdog touched reset path");
    property p_irq_gate;
        wdog_irq |-> $past(wdog_timeout_flag) && $past(extended_irq_enable[4]) &&
                     $past(global_irq_reg[7]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised without all enables");
    property p_locked_write;
        wdog_wr && ta_state != TA_OPEN && !wdog_sys_rst |=> $stable(wdog_reset_enable) &&
            $stable(running) && !$fell(wdog_timeout_flag) &&
            (cnt != '0 || !running || $past(cnt) == $past(limit_m1));
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("protected bits changed outside window");
    property p_wdrst_restarts;
        $fell(wdog_sys_rst) |-> running && cnt == '0 && !wdog_timeout_flag;
    endproperty
    a_wdrst_restarts: assert property (p_wdrst_restarts)
        else $error("watchdog reset did not restart counter");

    c_timeout: cover property (timeout);
    c_wd_reset: cover property ($rose(wdog_sys_rst));
    c_grace_restart: cover property (grace_on && wdog_restart);
    c_ta_open: cover property (ta_state == TA_OPEN ##1 prot_wr);

endmodule

// [tb/tb_system_watchdog_timer.sv]
// Purpose: Self-checking bench for the system watchdog timer over AXI4-Lite
// Assumes: Short interval parameters; bus answers per the hand-over timing
// Notes:   Cycle stamps are taken at the sampling edge of each handshake
`timescale 1ns/1ps
module tb_system_watchdog_timer;
    import swt_pkg::*;
    localparam int TO [4] = '{640, 704, 768, 832};
    logic clock;
    logic rst_n;
    swt_axil_req_t req;
    swt_axil_rsp_t rsp;
    logic wdog_irq;
    logic wdog_sys_rst;
    logic [31:0] cyc;
    logic [31:0] t_wr;
    logic [31:0] t_hit;
    logic [31:0] t0;
    logic [31:0] c;
    int n_errors;
    int cmp_count;

    swt_watchdog #(.CNT_W(27), .TO_CLKS_0(TO[0]), .TO_CLKS_1(TO[1]), .TO_CLKS_2(TO[2]),
        .TO_CLKS_3(TO[3])) swt_watchdog_i (.clock(clock), .rst_n(rst_n), .req(req),
        .rsp(rsp), .wdog_irq(wdog_irq), .wdog_sys_rst(wdog_sys_rst));

    // ------------------------------------------------------------
    // Clock and cycle stamp
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 32'h1;
    end

    // ------------------------------------------------------------
    // Report and compare helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang(input string what);
        n_errors++;
        $display("FAIL %s expected an answer seen timeout", what);
        conclude();
    endtask

    // ------------------------------------------------------------
    // Bus master tasks
    // ------------------------------------------------------------
    // Offers address and data together, holds until taken, then takes the response
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        k = 0;
        do begin @(posedge clock); k++; end while (rsp.awready !== 1'b1 && k < 50);
        if (k >= 50) hang("write address");
        t_wr = cyc;
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        k = 0;
        do begin @(posedge clock); k++; end while (rsp.bvalid !== 1'b1 && k < 50);
        if (k >= 50) hang("write response");
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        k = 0;
        do begin @(posedge clock); k++; end while (rsp.arready !== 1'b1 && k < 50);
        if (k >= 50) hang("read address");
        req.arvalid <= 1'b0;
        k = 0;
        do begin @(posedge clock); k++; end while (rsp.rvalid !== 1'b1 && k < 50);
        if (k >= 50) hang("read data");
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
        chk("register", e, d & m);
    endtask
    task automatic unlock();
        wr(OFF_TAKEY, {24'h0, TA_KEY1});
        wr(OFF_TAKEY, {24'h0, TA_KEY2});
    endtask
    // Waits for the reset or interrupt output, stamping the edge that sees it
    task automatic wait_out(input bit on_rst, input int bound);
        int k;
        k = 0;
        do begin @(posedge clock); k++; end
            while ((on_rst ? wdog_sys_rst : wdog_irq) !== 1'b1 && k < bound);
        if (k >= bound) hang("watchdog output");
        t_hit = cyc;
    endtask
    task automatic count_rst(input int n, output logic [31:0] cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clock);
            if (wdog_sys_rst === 1'b1) cnt++;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        req = '0;
        rst_n = 1'b0;
        cyc = 32'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, then unmapped place answers with an error
        rd(OFF_WDOG, 32'hff, 32'h0);
        rd(OFF_CLKCFG, 32'hff, {24'h0, CLKCFG_RESET});
        rd(OFF_IRQEN, 32'hff, {24'h0, IRQEN_RESET});
        rd(OFF_GIRQ, 32'hff, {24'h0, GIRQ_RESET});
        axr(8'h20, d, r);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped rdata", 32'h0, d);
        axw(8'h20, 32'hff, r);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        // Unguarded and wrong-key writes leave the watchdog stopped
        wr(OFF_IRQEN, 32'h10);
        wr(OFF_WDOG, 32'h0b);
        wr(OFF_TAKEY, {24'h0, TA_KEY1});
        wr(OFF_TAKEY, 32'h33);
        wr(OFF_WDOG, 32'h01);
        unlock();
        repeat (20) @(posedge clock);
        wr(OFF_WDOG, 32'h01);
        repeat (700) @(posedge clock);
        rd(OFF_WDOG, 32'hff, 32'h0);
        // Flag without global enable gives no interrupt until enabled
        unlock();
        wr(OFF_WDOG, 32'h01);
        repeat (660) @(posedge clock);
        chk("irq gated", 32'h0, {31'h0, wdog_irq});
        rd(OFF_WDOG, 32'hff, 32'h08);
        wr(OFF_GIRQ, 32'h80);
        repeat (2) @(posedge clock);
        chk("irq enabled", 32'h1, {31'h0, wdog_irq});
        // Every interval select, timed from the restart to the interrupt
        for (int s = 0; s < 4; s++) begin
            wr(OFF_CLKCFG, {24'h0, s[1:0], 6'h00});
            rd(OFF_CLKCFG, 32'hff, {24'h0, s[1:0], 6'h00});
            unlock();
            wr(OFF_WDOG, 32'h01);
            t0 = t_wr;
            @(posedge clock);
            wait_out(1'b0, 2000);
            chk("interval", TO[s] + 2, t_hit - t0);
            rd(OFF_WDOG, 32'hff, 32'h08);
        end
        // Clearing the flag without restart: next flag one interval later
        t0 = t_hit;
        unlock();
        wr(OFF_WDOG, 32'h00);
        @(posedge clock);
        wait_out(1'b0, 2000);
        chk("period", TO[3], t_hit - t0);
        // Armed reset fires after the grace period and lasts eight clocks
        wr(OFF_CLKCFG, 32'h00);
        unlock();
        wr(OFF_WDOG, 32'h03);
        t0 = t_wr;
        wait_out(1'b1, 2000);
        chk("reset delay", TO[0] + 513, t_hit - t0);
        count_rst(20, c);
        chk("reset width", 32'h7, c);
        rd(OFF_WDOG, 32'hff, 32'h06);
        wr(OFF_WDOG, 32'h00);
        rd(OFF_WDOG, 32'h06, 32'h02);
        // Restart inside the grace period cancels the pending reset
        wait_out(1'b0, 1000);
        unlock();
        wr(OFF_WDOG, 32'h03);
        count_rst(600, c);
        chk("cancelled reset", 32'h0, c);
        // Power reset clears and stops the watchdog
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFF_WDOG, 32'hff, 32'h0);
        repeat (900) @(posedge clock);
        rd(OFF_WDOG, 32'hff, 32'h0);
        chk("irq after reset", 32'h0, {31'h0, wdog_irq});
        conclude();
    end
endmodule
